// *** verilog/dtc_top.sv ***
// Dual timer/counter with mode, run control and external interrupt flag, Wishbone slave
`default_nettype none
`timescale 1ns/1ps
module dtc_top (
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    // Wishbone slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [9:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    // Pins
    input  wire logic        chan0_count_pin_in,
    input  wire logic        chan1_count_pin_in,
    input  wire logic        ext_irq_a_pin_in,
    input  wire logic        ext_irq_b_pin_in,
    // Cycle length and vectoring acknowledges
    input  wire logic        fast_cycle_in,
    input  wire logic        vec_chan0_in,
    input  wire logic        vec_chan1_in,
    input  wire logic        vec_ext_a_in,
    // Status
    output logic             chan0_overflow_flag_out,
    output logic             chan1_overflow_flag_out,
    output logic             ext_irq_a_flag_out
);
    logic [7:0]  run_ctl_q;
    logic [7:0]  mode_cfg_q;
    logic [7:0]  lo_q [2];
    logic [7:0]  hi_q [2];
    logic [1:0]  pend_q;
    logic [1:0]  pin_prev_q;
    logic        ext_prev_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic        ovf0_q;
    logic        ovf1_q;
    logic        eflag_q;
    logic [1:0]  cnt_pin_w;
    logic [1:0]  gate_pin_w;
    logic        sample_w;
    logic        update_w;
    logic        req_w;
    logic        wr_w;
    logic [7:0]  idx_w;
    logic [1:0]  ovf_w;
    logic        ext_edge_q;

    // Level and edge detection on synchronised pins
    dtc_sync u_sync_c0 (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .pin_in(chan0_count_pin_in), .level_out(cnt_pin_w[0]));
    dtc_sync u_sync_c1 (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .pin_in(chan1_count_pin_in), .level_out(cnt_pin_w[1]));
    dtc_sync u_sync_ga (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .pin_in(ext_irq_a_pin_in), .level_out(gate_pin_w[0]));
    dtc_sync u_sync_gb (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .pin_in(ext_irq_b_pin_in), .level_out(gate_pin_w[1]));

    dtc_cycle u_cycle (
        .mclk_in    (mclk_in),
        .rst_n_in   (rst_n_in),
        .fast_in    (fast_cycle_in),
        .sample_out (sample_w),
        .update_out (update_w)
    );

    assign req_w = wb_cyc_in && wb_stb_in && !ack_q;
    assign wr_w  = req_w && wb_we_in && wb_sel_in[0];
    assign idx_w = wb_adr_in[9:2];

    // Nibble field extraction for a channel
    function automatic logic [3:0] nib(input logic [7:0] cfg, input int ch);
        nib = ch == 1 ? cfg[7:4] : cfg[3:0];
    endfunction : nib

    // Whether a channel's count is enabled this cycle
    function automatic logic enabled(input logic run, input logic [3:0] n, input logic gpin);
        enabled = run && (!n[dtc_pkg::GATE_BIT] || gpin);
    endfunction : enabled

    // Bus write strobes per channel byte
    logic [1:0] wr_lo_w;
    logic [1:0] wr_hi_w;
    assign wr_lo_w[0] = wr_w && idx_w == dtc_pkg::CHAN0_LOW_IDX;
    assign wr_lo_w[1] = wr_w && idx_w == dtc_pkg::CHAN1_LOW_IDX;
    assign wr_hi_w[0] = wr_w && idx_w == dtc_pkg::CHAN0_HIGH_IDX;
    assign wr_hi_w[1] = wr_w && idx_w == dtc_pkg::CHAN1_HIGH_IDX;

    logic split_w;
    assign split_w = mode_cfg_q[1:0] == dtc_pkg::DTC_SPLIT;

    // Per channel: sample, pend, then apply at update point
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_chan
            logic [3:0] n_w;
            logic       src_ev_w;
            logic       run_w;
            assign n_w   = nib(mode_cfg_q, g);
            assign run_w = run_ctl_q[g == 1 ? dtc_pkg::CH1_RUN_BIT : dtc_pkg::CH0_RUN_BIT];
            // Pin falls between consecutive samples
            assign src_ev_w = n_w[dtc_pkg::SRC_BIT] ? (pin_prev_q[g] && !cnt_pin_w[g]) : 1'b1;

            always_ff @(posedge mclk_in) begin
                if (!rst_n_in) begin
                    pin_prev_q[g] <= 1'b1;
                    pend_q[g]     <= 1'b0;
                end else if (sample_w) begin
                    pin_prev_q[g] <= cnt_pin_w[g];
                    pend_q[g]     <= src_ev_w && enabled(run_w, n_w, gate_pin_w[g]);
                end else if (update_w) begin
                    pend_q[g] <= 1'b0;
                end
            end

            always_ff @(posedge mclk_in) begin
                if (!rst_n_in) begin
                    lo_q[g]    <= 8'h00;
                    hi_q[g]    <= 8'h00;
                    ovf_w[g]   <= 1'b0;
                end else begin
                    ovf_w[g] <= 1'b0;
                    if (wr_lo_w[g]) begin
                        lo_q[g] <= wb_dat_in[7:0];
                    end else if (update_w && pend_q[g]) begin
                        case (n_w[1:0])
                            dtc_pkg::DTC_MODE13: begin
                                lo_q[g] <= {3'h0, lo_q[g][4:0] + 5'h01};
                                if (lo_q[g][4:0] == 5'h1F) begin
                                    ovf_w[g] <= hi_q[g] == 8'hFF;
                                end
                            end
                            dtc_pkg::DTC_MODE16: begin
                                lo_q[g] <= lo_q[g] + 8'h01;
                                ovf_w[g] <= lo_q[g] == 8'hFF && hi_q[g] == 8'hFF;
                            end
                            dtc_pkg::DTC_RELOAD8: begin
                                lo_q[g]  <= lo_q[g] == 8'hFF ? hi_q[g] : lo_q[g] + 8'h01;
                                ovf_w[g] <= lo_q[g] == 8'hFF;
                            end
                            default: begin
                                // Channel 1 holds; channel 0 low byte counts alone
                                if (g == 0) begin
                                    lo_q[g]  <= lo_q[g] + 8'h01;
                                    ovf_w[g] <= lo_q[g] == 8'hFF;
                                end
                            end
                        endcase
                    end
                    if (wr_hi_w[g]) begin
                        hi_q[g] <= wb_dat_in[7:0];
                    end else if (g == 0 && split_w && update_w
                                 && run_ctl_q[dtc_pkg::CH1_RUN_BIT]) begin
                        hi_q[g] <= hi_q[g] + 8'h01;
                    end else if (update_w && pend_q[g]) begin
                        if ((n_w[1:0] == dtc_pkg::DTC_MODE13 && lo_q[g][4:0] == 5'h1F)
                            || (n_w[1:0] == dtc_pkg::DTC_MODE16 && lo_q[g] == 8'hFF)) begin
                            hi_q[g] <= hi_q[g] + 8'h01;
                        end
                    end
                end
            end
        end
    endgenerate

    // Split high byte overflow drives channel 1 flag
    logic split_hi_ovf_w;
    assign split_hi_ovf_w = split_w && update_w && run_ctl_q[dtc_pkg::CH1_RUN_BIT]
                            && hi_q[0] == 8'hFF && !wr_hi_w[0];

    // Channel 1 flag comes only from split high byte while channel 0 splits
    logic set1_w;
    assign set1_w = split_w ? split_hi_ovf_w : ovf_w[1];

    // External flag: edge or level
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            ext_prev_q <= 1'b1;
            ext_edge_q <= 1'b0;
        end else begin
            ext_prev_q <= gate_pin_w[0];
            ext_edge_q <= ext_prev_q && !gate_pin_w[0];
        end
    end

    // Control register; hardware set beats any clear
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            run_ctl_q <= dtc_pkg::RUN_CONTROL_RST;
        end else begin
            if (wr_w && idx_w == dtc_pkg::RUN_CONTROL_IDX) begin
                run_ctl_q <= wb_dat_in[7:0] & 8'hF3;
            end
            if (vec_chan0_in) begin
                run_ctl_q[dtc_pkg::CH0_OVF_BIT] <= 1'b0;
            end
            if (vec_chan1_in) begin
                run_ctl_q[dtc_pkg::CH1_OVF_BIT] <= 1'b0;
            end
            if (ovf_w[0]) begin
                run_ctl_q[dtc_pkg::CH0_OVF_BIT] <= 1'b1;
            end
            if (set1_w) begin
                run_ctl_q[dtc_pkg::CH1_OVF_BIT] <= 1'b1;
            end
            if (!run_ctl_q[dtc_pkg::EXT_TYPE_BIT]) begin
                run_ctl_q[dtc_pkg::EXT_FLAG_BIT] <= !gate_pin_w[0];
            end else begin
                if (vec_ext_a_in) begin
                    run_ctl_q[dtc_pkg::EXT_FLAG_BIT] <= 1'b0;
                end
                if (ext_edge_q) begin
                    run_ctl_q[dtc_pkg::EXT_FLAG_BIT] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            mode_cfg_q <= dtc_pkg::MODE_CONFIG_RST;
        end else if (wr_w && idx_w == dtc_pkg::MODE_CONFIG_IDX) begin
            mode_cfg_q <= wb_dat_in[7:0];
        end
    end

    // Bus answer one cycle after request; unmapped reads return zero
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req_w;
            case (idx_w)
                dtc_pkg::RUN_CONTROL_IDX: rdat_q <= {24'h000000, run_ctl_q};
                dtc_pkg::MODE_CONFIG_IDX: rdat_q <= {24'h000000, mode_cfg_q};
                dtc_pkg::CHAN0_LOW_IDX:   rdat_q <= {24'h000000, lo_q[0]};
                dtc_pkg::CHAN1_LOW_IDX:   rdat_q <= {24'h000000, lo_q[1]};
                dtc_pkg::CHAN0_HIGH_IDX:  rdat_q <= {24'h000000, hi_q[0]};
                dtc_pkg::CHAN1_HIGH_IDX:  rdat_q <= {24'h000000, hi_q[1]};
                default:                  rdat_q <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            ovf0_q  <= 1'b0;
            ovf1_q  <= 1'b0;
            eflag_q <= 1'b0;
        end else begin
            ovf0_q  <= run_ctl_q[dtc_pkg::CH0_OVF_BIT];
            ovf1_q  <= run_ctl_q[dtc_pkg::CH1_OVF_BIT];
            eflag_q <= run_ctl_q[dtc_pkg::EXT_FLAG_BIT];
        end
    end

    assign wb_ack_out              = ack_q;
    assign wb_dat_out              = rdat_q;
    assign chan0_overflow_flag_out = ovf0_q;
    assign chan1_overflow_flag_out = ovf1_q;
    assign ext_irq_a_flag_out      = eflag_q;

    // Overflow in 8-bit reload leaves the low byte at the high byte value
    reload_value_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (ovf_w[1] && mode_cfg_q[5:4] == dtc_pkg::DTC_RELOAD8 && !split_w && !$past(wr_lo_w[1]))
        |-> lo_q[1] == hi_q[1]) else $error("reload missing");
    flag_follows_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        ovf_w[0] |=> run_ctl_q[dtc_pkg::CH0_OVF_BIT]) else $error("overflow flag not set");
    stop_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (mode_cfg_q[5:4] == dtc_pkg::DTC_SPLIT && !wr_lo_w[1]) |=> $stable(lo_q[1])) else $error("ch1 moved");
    run_gate_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (sample_w && !run_ctl_q[dtc_pkg::CH0_RUN_BIT]) |=> !pend_q[0]) else $error("count while stopped");
    level_type_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (!run_ctl_q[dtc_pkg::EXT_TYPE_BIT] && !$past(wr_w)) |=> run_ctl_q[dtc_pkg::EXT_FLAG_BIT] == !$past(gate_pin_w[0]))
        else $error("level flag mismatch");
    mode13_top_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (update_w && pend_q[0] && mode_cfg_q[1:0] == dtc_pkg::DTC_MODE13 && !wr_lo_w[0])
        |=> lo_q[0][7:5] == 3'h0) else $error("mode 0 upper bits");
    bus_ack_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        req_w |=> wb_ack_out ##1 !wb_ack_out) else $error("ack timing");
    reserved_zero_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        run_ctl_q[3:2] == 2'h0) else $error("reserved bits set");
endmodule : dtc_top
`default_nettype wire

// *** verilog/dtc_pkg.sv ***
// Package: register map, field positions and timing constants for the dual timer
`default_nettype none
package dtc_pkg;
    // Register offsets on the bus (word indices, not byte addresses, so byte address = 4 * index)
    localparam logic [7:0] RUN_CONTROL_IDX = 8'h88;
    localparam logic [7:0] MODE_CONFIG_IDX = 8'h89;
    localparam logic [7:0] CHAN0_LOW_IDX   = 8'h8A;
    localparam logic [7:0] CHAN1_LOW_IDX   = 8'h8B;
    localparam logic [7:0] CHAN0_HIGH_IDX  = 8'h8C;
    localparam logic [7:0] CHAN1_HIGH_IDX  = 8'h8D;
    localparam logic [7:0] VECTOR_ACK_IDX  = 8'h8E;
    // Reset values
    localparam logic [7:0] RUN_CONTROL_RST = 8'h00;
    localparam logic [7:0] MODE_CONFIG_RST = 8'h00;
    // Run control bit positions
    localparam int CH1_OVF_BIT  = 7;
    localparam int CH1_RUN_BIT  = 6;
    localparam int CH0_OVF_BIT  = 5;
    localparam int CH0_RUN_BIT  = 4;
    localparam int EXT_FLAG_BIT = 1;
    localparam int EXT_TYPE_BIT = 0;
    // Mode config nibble layout
    localparam int GATE_BIT    = 3;
    localparam int SRC_BIT     = 2;
    localparam int MODE_HI_BIT = 1;
    localparam int MODE_LO_BIT = 0;
    localparam int CH1_NIBBLE  = 4;
    // Machine cycle timing
    localparam int OSC_PER_CYCLE_SLOW = 12;
    localparam int OSC_PER_CYCLE_FAST = 6;
    localparam int SAMPLE_PHASE       = 9;
    localparam int UPDATE_PHASE       = 4;
    // Mode field encodings
    typedef enum logic [1:0] {
        DTC_MODE13  = 2'h0,
        DTC_MODE16  = 2'h1,
        DTC_RELOAD8 = 2'h2,
        DTC_SPLIT   = 2'h3
    } dtc_mode_type;
endpackage : dtc_pkg
`default_nettype wire

// *** verilog/dtc_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`default_nettype none
`timescale 1ns/1ps
module dtc_sync (
    // Clock and reset
    input  wire logic mclk_in,
    input  wire logic rst_n_in,
    // Pin and filtered level
    input  wire logic pin_in,
    output logic      level_out
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Change counts only once stages two and three agree
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            level_q <= 1'b1;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end

    assign level_out = level_q;
endmodule : dtc_sync
`default_nettype wire

// *** verilog/dtc_cycle.sv ***
// Machine cycle phase generator
`default_nettype none
`timescale 1ns/1ps
module dtc_cycle (
    // Clock and reset
    input  wire logic mclk_in,
    input  wire logic rst_n_in,
    // Cycle length select
    input  wire logic fast_in,
    // Phase strobes
    output logic      sample_out,
    output logic      update_out
);
    logic [3:0] phase_q;
    logic [3:0] last_w;

    assign last_w = fast_in ? 4'(dtc_pkg::OSC_PER_CYCLE_FAST - 1) : 4'(dtc_pkg::OSC_PER_CYCLE_SLOW - 1);

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            phase_q <= 4'h0;
        end else if (phase_q >= last_w) begin
            phase_q <= 4'h0;
        end else begin
            phase_q <= phase_q + 4'h1;
        end
    end

    // Fast cycles place both points within the shorter cycle
    assign sample_out = fast_in ? (phase_q == 4'(dtc_pkg::OSC_PER_CYCLE_FAST - 1))
                                : (phase_q == 4'(dtc_pkg::SAMPLE_PHASE));
    assign update_out = fast_in ? (phase_q == 4'h1) : (phase_q == 4'(dtc_pkg::UPDATE_PHASE));
endmodule : dtc_cycle
`default_nettype wire

// *** test/dtc_pin_model.sv ***
// Far-side pin model: count pins and gate/interrupt pins
`default_nettype none
`timescale 1ns/1ps
module dtc_pin_model (
    // Clock
    input  wire logic  mclk_in,
    // Pins, idle high
    output wire logic  chan0_count_pin_out,
    output wire logic  chan1_count_pin_out,
    output wire logic  ext_irq_a_pin_out,
    output wire logic  ext_irq_b_pin_out
);
    logic [1:0] lvl_q = 2'b11;
    logic [1:0] ext_q = 2'b11;
    assign chan0_count_pin_out = lvl_q[0];
    assign chan1_count_pin_out = lvl_q[1];
    assign ext_irq_a_pin_out   = ext_q[0];
    assign ext_irq_b_pin_out   = ext_q[1];
    // Levels shorter than one machine cycle may be missed, so callers keep hold above it
    task automatic falls(input int ch, input int n, input int hold);
        for (int i = 0; i < n; i++) begin
            repeat (hold) @(posedge mclk_in);
            lvl_q[ch] <= 1'b0;
            repeat (hold) @(posedge mclk_in);
            lvl_q[ch] <= 1'b1;
        end
    endtask : falls
    task automatic ext(input logic a, input logic b);
        @(posedge mclk_in);
        ext_q <= {b, a};
    endtask : ext
endmodule : dtc_pin_model
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the dual timer/counter
`default_nettype none
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] CT = dtc_pkg::RUN_CONTROL_IDX;
    localparam logic [7:0] MD = dtc_pkg::MODE_CONFIG_IDX;
    localparam logic [7:0] LO = dtc_pkg::CHAN0_LOW_IDX;
    localparam logic [7:0] HI = dtc_pkg::CHAN0_HIGH_IDX;
    logic        clk;
    logic        rst_n;
    logic        cyc;
    logic        stb;
    logic        wwe;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
    logic [31:0] rdat;
    logic        ack;
    logic        fast;
    logic        v0;
    logic        v1;
    logic        ve;
    logic        f0;
    logic        f1;
    logic        fe;
    logic        p0;
    logic        p1;
    logic        pa;
    logic        pb;
    int          fails;
    int          num_checks;

    dtc_top dut (.mclk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(wwe),
        .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .chan0_count_pin_in(p0), .chan1_count_pin_in(p1), .ext_irq_a_pin_in(pa), .ext_irq_b_pin_in(pb),
        .fast_cycle_in(fast), .vec_chan0_in(v0), .vec_chan1_in(v1), .vec_ext_a_in(ve),
        .chan0_overflow_flag_out(f0), .chan1_overflow_flag_out(f1), .ext_irq_a_flag_out(fe));
    dtc_pin_model pins (.mclk_in(clk), .chan0_count_pin_out(p0), .chan1_count_pin_out(p1),
        .ext_irq_a_pin_out(pa), .ext_irq_b_pin_out(pb));

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Request held until the edge that samples ack; no fixed latency assumed
    task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, wwe, adr, dat} <= {2'b11, we, idx, 2'b00, 24'h0, wd};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        rd = rdat[7:0];
        {cyc, stb} <= 2'b00;
        if (n >= 40) fails++;
    endtask : bus
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, idx, d, x);
    endtask : wr
    task automatic cnt(input int c, output logic [15:0] v);
        bus(1'b0, HI + 8'(c), 8'h00, v[15:8]);
        bus(1'b0, LO + 8'(c), 8'h00, v[7:0]);
    endtask : cnt
    // Control writes keep reserved bits 3:2 at zero
    task automatic load(input int c, input logic [15:0] v, input logic [7:0] mode, input logic [7:0] ctl);
        wr(CT, 8'h00);
        wr(MD, mode);
        wr(HI + 8'(c), v[15:8]);
        wr(LO + 8'(c), v[7:0]);
        wr(CT, ctl);
    endtask : load
    task automatic wflag(input int w, input logic v, input int lim);
        int n;
        logic [2:0] fl;
        n = 0;
        fl = {fe, f1, f0};
        while (fl[w] !== v && n < lim) begin
            @(posedge clk);
            n++;
            fl = {fe, f1, f0};
        end
        chk("flag", {15'h0, fl[w]}, {15'h0, v});
    endtask : wflag
    task automatic vec(input int w);
        @(posedge clk);
        {ve, v1, v0} <= 3'(1 << w);
        @(posedge clk);
        {ve, v1, v0} <= 3'b000;
    endtask : vec

    task automatic t_regs();
        logic [7:0] r;
        bus(1'b0, CT, 8'h00, r);
        chk("ctrl_rst", {8'h00, r}, 16'h0000);
        bus(1'b0, MD, 8'h00, r);
        chk("mode_rst", {8'h00, r}, 16'h0000);
        wr(MD, 8'hA5);
        bus(1'b0, MD, 8'h00, r);
        chk("mode_rw", {8'h00, r}, 16'h00A5);
        bus(1'b0, dtc_pkg::VECTOR_ACK_IDX, 8'h00, r);
        chk("unmapped", {8'h00, r}, 16'h0000);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_timer();
        logic [15:0] v;
        for (int f = 0; f < 2; f++) begin
            fast <= f[0];
            load(0, 16'h0000, 8'h01, 8'h10);
            repeat (240) @(posedge clk);
            wr(CT, 8'h00);
            cnt(0, v);
            chk("rate", {15'h0, v >= 16'(19 + 20 * f) && v <= 16'(21 + 20 * f)}, 16'h0001);
        end
        fast <= 1'b0;
        load(0, 16'hFFFF, 8'h01, 8'h10);
        wflag(0, 1'b1, 40);
        wr(CT, 8'h20);
        cnt(0, v);
        chk("wrap16", {15'h0, v <= 16'h0002}, 16'h0001);
        vec(0);
        wflag(0, 1'b0, 5);
        wr(CT, 8'h20);
        wflag(0, 1'b1, 5);
        load(0, 16'h1FFF, 8'h01, 8'h10);
        repeat (24) @(posedge clk);
        wr(CT, 8'h00);
        cnt(0, v);
        chk("no13", {14'h0, f0, v >= 16'h2000 && v <= 16'h2003}, 16'h0001);
        $display("t_timer done");
    endtask : t_timer
    task automatic t_modes();
        logic [15:0] v;
        // Low byte 1F: all ones in 13 bits, far from a 16-bit wrap
        load(0, 16'hFF1F, 8'h00, 8'h10);
        wflag(0, 1'b1, 40);
        wr(CT, 8'h00);
        cnt(0, v);
        chk("wrap13", {15'h0, v <= 16'h0002}, 16'h0001);
        load(1, 16'hC0FF, 8'h20, 8'h40);
        wflag(1, 1'b1, 40);
        wr(CT, 8'h00);
        cnt(1, v);
        chk("reload", {15'h0, v >= 16'hC0C0 && v <= 16'hC0C2}, 16'h0001);
        pins.ext(1'b0, 1'b1);
        load(0, 16'h0000, 8'h09, 8'h10);
        repeat (60) @(posedge clk);
        cnt(0, v);
        chk("gated", v, 16'h0000);
        pins.ext(1'b1, 1'b1);
        repeat (60) @(posedge clk);
        wr(CT, 8'h00);
        cnt(0, v);
        chk("ungated", {15'h0, v >= 16'h0003 && v <= 16'h0006}, 16'h0001);
        $display("t_modes done");
    endtask : t_modes
    task automatic t_events();
        logic [15:0] v;
        load(1, 16'h0000, 8'h50, 8'h40);
        pins.falls(1, 5, 14);
        pins.falls(1, 4, 40);
        repeat (36) @(posedge clk);
        cnt(1, v);
        chk("events", v, 16'h0009);
        $display("t_events done");
    endtask : t_events
    task automatic t_split();
        logic [15:0] v;
        wr(CT, 8'h00);
        wr(MD, 8'h33);
        wr(LO + 8'd1, 8'h55);
        wr(HI, 8'hFE);
        wr(LO, 8'h00);
        wr(CT, 8'h40);
        wflag(1, 1'b1, 60);
        wr(CT, 8'h40);
        cnt(1, v);
        chk("ch1_hold", v, 16'h0055);
        cnt(0, v);
        chk("ch0_split", {14'h0, f0, v[7:0] == 8'h00}, 16'h0001);
        vec(1);
        wflag(1, 1'b0, 5);
        $display("t_split done");
    endtask : t_split
    task automatic t_ext();
        wr(MD, 8'h00);
        wr(CT, 8'h01);
        pins.ext(1'b0, 1'b1);
        wflag(2, 1'b1, 20);
        vec(2);
        wflag(2, 1'b0, 5);
        repeat (8) @(posedge clk);
        chk("edge_once", {15'h0, fe}, 16'h0000);
        pins.ext(1'b1, 1'b1);
        wr(CT, 8'h00);
        pins.ext(1'b0, 1'b1);
        wflag(2, 1'b1, 20);
        vec(2);
        repeat (4) @(posedge clk);
        chk("level_kept", {15'h0, fe}, 16'h0001);
        pins.ext(1'b1, 1'b1);
        wflag(2, 1'b0, 20);
        $display("t_ext done");
    endtask : t_ext

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        {rst_n, cyc, stb, wwe, adr, dat, fast, v0, v1, ve} = '0;
        sel = 4'h1;
        fails = 0;
        num_checks = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        // Let the pin synchronisers settle before the first read
        repeat (6) @(posedge clk);
        t_regs();
        t_timer();
        t_modes();
        t_events();
        t_split();
        t_ext();
        end_of_test();
    end
    // Whole run is a few thousand cycles; this bound only catches a hang
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
